// ==== core/alu_map.vh ====
`ifndef ALU_MAP_VH
`define ALU_MAP_VH

`define ALU_OP_DEC    4'h0
`define ALU_OP_DECC   4'h1
`define ALU_OP_AND    4'h2
`define ALU_OP_OR     4'h3
`define ALU_OP_XOR    4'h4
`define ALU_OP_ADD    4'h5
`define ALU_OP_ADDC   4'h6
`define ALU_OP_SUBD   4'h7
`define ALU_OP_SUBDC  4'h8
`define ALU_OP_SUBS   4'h9
`define ALU_OP_SUBSC  4'hA

`define ALU_FORM_IMM  3'h0
`define ALU_FORM_R1   3'h1
`define ALU_FORM_R2   3'h2
`define ALU_FORM_R3   3'h3
`define ALU_FORM_MEM  3'h4

`define ALU_LOG_AND   2'h0
`define ALU_LOG_OR    2'h1
`define ALU_LOG_XOR   2'h2

`define ALU_BYTE_ONE  8'h01
`define ALU_BYTE_FF   8'hFF
`define ALU_BYTE_ZERO 8'h00
`define ALU_FLAG_RST  1'h0

`endif

// ==== core/alu_addsub.v ====
`timescale 1ns/1ps
`default_nettype none
module alu_addsub #(
  parameter W = 8
) (
  input  wire [W-1:0] i_p,
  input  wire [W-1:0] i_q,
  input  wire         i_sub,
  input  wire         i_cin,
  output wire [W-1:0] o_sum,
  output wire         o_cout,
  output wire         o_ovf
);
  // subtraction is p + ~q + cin, so carry out is the inverted borrow
  wire [W-1:0] q_eff;
  wire [W:0]   full;

  assign q_eff  = i_sub ? ~i_q : i_q;
  assign full   = {1'b0, i_p} + {1'b0, q_eff} + {{W{1'b0}}, i_cin};
  assign o_sum  = full[W-1:0];
  assign o_cout = full[W];
  // signed overflow: same-sign addends giving a result of the other sign
  assign o_ovf  = (i_p[W-1] == q_eff[W-1]) && (full[W-1] != i_p[W-1]);
endmodule // alu_addsub
`default_nettype wire

// ==== core/alu_logic.v ====
`timescale 1ns/1ps
`default_nettype none
`include "alu_map.vh"
module alu_logic #(
  parameter W = 8
) (
  input  wire [W-1:0] i_x,
  input  wire [W-1:0] i_y,
  input  wire [1:0]   i_sel,
  output reg  [W-1:0] o_res
);
  always @* begin
    case (i_sel)
      `ALU_LOG_AND: o_res = i_x & i_y;
      `ALU_LOG_OR:  o_res = i_x | i_y;
      `ALU_LOG_XOR: o_res = i_x ^ i_y;
      default:      o_res = i_x & i_y;
    endcase
  end
endmodule // alu_logic
`default_nettype wire

// ==== core/alu_core.v ====
`timescale 1ns/1ps
`default_nettype none
`include "alu_map.vh"
module alu_core #(
  parameter W     = 8,
  parameter AW    = 16,
  parameter RSELW = 4
) (
  input  wire             I_REF_CLK,
  input  wire             I_SYS_RST,
  input  wire             I_OP_VALID,
  input  wire [3:0]       I_OP_CODE,
  input  wire [2:0]       I_OP_FORM,
  input  wire [RSELW-1:0] I_DST_SEL,
  input  wire [W-1:0]     I_REG1,
  input  wire [W-1:0]     I_REG2,
  input  wire [W-1:0]     I_REG3,
  input  wire [W-1:0]     I_IMM,
  input  wire [AW-1:0]    I_EADDR,
  input  wire [W-1:0]     I_DS_RDATA,
  output wire             O_BUSY,
  output reg              O_DS_RD,
  output reg  [AW-1:0]    O_DS_ADDR,
  output reg              O_IDX_UPD,
  output reg              O_WB_EN,
  output reg  [RSELW-1:0] O_WB_SEL,
  output reg  [W-1:0]     O_WB_DATA,
  output reg  [W-1:0]     O_ACC,
  output reg              O_FLAG_C,
  output reg              O_FLAG_V,
  output reg              O_FLAG_Z,
  output reg              O_DONE
);

  localparam [1:0] ST_IDLE  = 2'h0;
  localparam [1:0] ST_FETCH = 2'h1;
  localparam [1:0] ST_EXEC  = 2'h2;

  // true for the operations that do not touch carry or overflow
  function is_logic;
    input [3:0] op;
    begin
      is_logic = (op == `ALU_OP_AND) || (op == `ALU_OP_OR) || (op == `ALU_OP_XOR);
    end
  endfunction

  // true for the operations that take the incoming carry
  function uses_carry;
    input [3:0] op;
    begin
      uses_carry = (op == `ALU_OP_DECC) || (op == `ALU_OP_ADDC) ||
                   (op == `ALU_OP_SUBDC) || (op == `ALU_OP_SUBSC);
    end
  endfunction

  function is_known;
    input [3:0] op;
    begin
      is_known = (op <= `ALU_OP_SUBSC);
    end
  endfunction

  // memory forms fetch their operand from the data store first
  function is_mem;
    input [2:0] f;
    begin
      is_mem = (f == `ALU_FORM_MEM);
    end
  endfunction

  reg  [1:0]       state;
  reg  [1:0]       next_state;
  reg  [3:0]       op;
  reg  [2:0]       form;
  reg  [RSELW-1:0] dst;
  reg  [W-1:0]     r1;
  reg  [W-1:0]     r2;
  reg  [W-1:0]     r3;
  reg  [W-1:0]     imm;

  wire             accept;
  wire             is_dec;
  wire             is_add;
  wire             is_subd;
  wire             is_subs;
  wire             swap;
  reg  [W-1:0]     opnd_x;
  reg  [W-1:0]     opnd_y;
  reg  [W-1:0]     dec_src;
  reg  [W-1:0]     as_p;
  reg  [W-1:0]     as_q;
  reg              as_sub;
  reg              as_cin;
  wire [W-1:0]     as_sum;
  wire             as_cout;
  wire             as_ovf;
  reg  [1:0]       log_sel;
  wire [W-1:0]     log_res;
  reg  [W-1:0]     result;
  reg              next_c;
  reg              next_v;

  // a request while busy is dropped: there is no queue
  assign accept = I_OP_VALID && (state == ST_IDLE);
  assign O_BUSY = (state != ST_IDLE);

  // capture the request so the register file may move on
  always @(posedge I_REF_CLK) begin
    if (I_SYS_RST) begin
      op   <= `ALU_OP_DEC;
      form <= `ALU_FORM_IMM;
      dst  <= {RSELW{1'b0}};
      r1   <= `ALU_BYTE_ZERO;
      r2   <= `ALU_BYTE_ZERO;
      r3   <= `ALU_BYTE_ZERO;
      imm  <= `ALU_BYTE_ZERO;
    end else if (accept) begin
      op   <= I_OP_CODE;
      form <= I_OP_FORM;
      dst  <= I_DST_SEL;
      r1   <= I_REG1;
      r2   <= I_REG2;
      r3   <= I_REG3;
      imm  <= I_IMM;
    end
  end

  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (accept) begin
          if (is_mem(I_OP_FORM)) begin
            next_state = ST_FETCH;
          end else begin
            next_state = ST_EXEC;
          end
        end
      end
      ST_FETCH: next_state = ST_EXEC;
      ST_EXEC:  next_state = ST_IDLE;
      default:  next_state = ST_IDLE;
    endcase
  end

  always @(posedge I_REF_CLK) begin
    if (I_SYS_RST) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // memory forms: one read strobe at the extended address with its index update
  always @(posedge I_REF_CLK) begin
    if (I_SYS_RST) begin
      O_DS_RD   <= 1'b0;
      O_IDX_UPD <= 1'b0;
      O_DS_ADDR <= {AW{1'b0}};
    end else begin
      O_DS_RD   <= accept && is_mem(I_OP_FORM);
      O_IDX_UPD <= accept && is_mem(I_OP_FORM);
      if (accept) begin
        O_DS_ADDR <= I_EADDR;
      end
    end
  end

  // operand pair: x is the register side, y the other source
  always @* begin
    case (form)
      `ALU_FORM_IMM: begin
        opnd_x = r1;
        opnd_y = imm;
      end
      `ALU_FORM_R3: begin
        opnd_x = r2;
        opnd_y = r3;
      end
      `ALU_FORM_MEM: begin
        opnd_x = r1;
        opnd_y = I_DS_RDATA;
      end
      default: begin
        opnd_x = r1;
        opnd_y = r2;
      end
    endcase
  end

  // decrement source: the single register, the second register, or the store
  always @* begin
    case (form)
      `ALU_FORM_R2:  dec_src = r2;
      `ALU_FORM_MEM: dec_src = I_DS_RDATA;
      default:       dec_src = r1;
    endcase
  end

  assign is_dec  = (op == `ALU_OP_DEC) || (op == `ALU_OP_DECC);
  assign is_add  = (op == `ALU_OP_ADD) || (op == `ALU_OP_ADDC);
  assign is_subd = (op == `ALU_OP_SUBD) || (op == `ALU_OP_SUBDC);
  assign is_subs = (op == `ALU_OP_SUBS) || (op == `ALU_OP_SUBSC);
  // reversed subtraction is y - x, except the three-register form which is x - y
  assign swap    = is_subd ^ (form == `ALU_FORM_R3);

  always @* begin
    as_p   = opnd_x;
    as_q   = opnd_y;
    as_sub = 1'b0;
    as_cin = 1'b0;
    if (is_dec) begin
      as_p   = dec_src;
      // plain decrement is p + ~1 + 1; p - (1 - C) is p + ~0 + C
      // a subtrahend of one with carry in C would take off one too many
      as_q   = uses_carry(op) ? `ALU_BYTE_ZERO : `ALU_BYTE_ONE;
      as_sub = 1'b1;
      as_cin = uses_carry(op) ? O_FLAG_C : 1'b1;
    end else if (is_add) begin
      as_cin = uses_carry(op) ? O_FLAG_C : 1'b0;
    end else if (is_subd || is_subs) begin
      as_p   = swap ? opnd_y : opnd_x;
      as_q   = swap ? opnd_x : opnd_y;
      as_sub = 1'b1;
      // minus (1 - C): carry in is C, plain form uses one
      as_cin = uses_carry(op) ? O_FLAG_C : 1'b1;
    end
  end

  alu_addsub #(
    .W (W)
  ) u_addsub (
    .i_p    (as_p),
    .i_q    (as_q),
    .i_sub  (as_sub),
    .i_cin  (as_cin),
    .o_sum  (as_sum),
    .o_cout (as_cout),
    .o_ovf  (as_ovf)
  );

  always @* begin
    case (op)
      `ALU_OP_OR:  log_sel = `ALU_LOG_OR;
      `ALU_OP_XOR: log_sel = `ALU_LOG_XOR; // memory form is xor too
      default:     log_sel = `ALU_LOG_AND;
    endcase
  end

  alu_logic #(
    .W (W)
  ) u_logic (
    .i_x   (opnd_x),
    .i_y   (opnd_y),
    .i_sel (log_sel),
    .o_res (log_res)
  );

  always @* begin
    result = as_sum;
    next_c = O_FLAG_C;
    next_v = O_FLAG_V;
    if (is_logic(op)) begin
      result = log_res;
    end else if (is_dec) begin
      // clear only on wrap to hFF; with carry in set there is no wrap
      next_c = !((as_sum == `ALU_BYTE_FF) &&
                 !(uses_carry(op) && O_FLAG_C));
      next_v = as_ovf;
    end else begin
      // add: carry is the carry out; subtract: carry out is the inverted borrow
      next_c = as_cout;
      next_v = as_ovf;
    end
  end

  // results land on the edge that closes the execute cycle
  always @(posedge I_REF_CLK) begin
    if (I_SYS_RST) begin
      O_WB_EN   <= 1'b0;
      O_WB_SEL  <= {RSELW{1'b0}};
      O_WB_DATA <= `ALU_BYTE_ZERO;
      O_ACC     <= `ALU_BYTE_ZERO;
      O_FLAG_C  <= `ALU_FLAG_RST;
      O_FLAG_V  <= `ALU_FLAG_RST;
      O_FLAG_Z  <= `ALU_FLAG_RST;
      O_DONE    <= 1'b0;
    end else begin
      O_WB_EN <= 1'b0;
      O_DONE  <= 1'b0;
      if (state == ST_EXEC) begin
        O_DONE <= 1'b1;
        if (is_known(op)) begin
          O_WB_EN   <= 1'b1;
          O_WB_SEL  <= dst;
          O_WB_DATA <= result;
          O_ACC     <= result;
          O_FLAG_C  <= next_c;
          O_FLAG_V  <= next_v;
          O_FLAG_Z  <= (result == `ALU_BYTE_ZERO);
        end
      end
    end
  end

endmodule // alu_core
`default_nettype wire

// ==== dv/alu_core_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
module alu_core_chk (
  input wire logic        I_REF_CLK,
  input wire logic        I_SYS_RST,
  input wire logic        I_OP_VALID,
  input wire logic [3:0]  I_OP_CODE,
  input wire logic [2:0]  I_OP_FORM,
  input wire logic [7:0]  I_REG1,
  input wire logic [7:0]  I_IMM,
  input wire logic [15:0] I_EADDR,
  input wire logic        O_BUSY,
  input wire logic        O_DS_RD,
  input wire logic        O_IDX_UPD,
  input wire logic [15:0] O_DS_ADDR,
  input wire logic        O_WB_EN,
  input wire logic [7:0]  O_WB_DATA,
  input wire logic [7:0]  O_ACC,
  input wire logic        O_FLAG_C,
  input wire logic        O_FLAG_V,
  input wire logic        O_FLAG_Z,
  input wire logic        O_DONE
);
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (I_SYS_RST);
  wire tk = I_OP_VALID && !O_BUSY;
  wire mem = I_OP_FORM == 3'h4;
  wire lg = I_OP_CODE >= 4'h2 && I_OP_CODE <= 4'h4;
  property p_nm_lat; tk && !mem |=> !O_DONE ##1 O_DONE; endproperty
  a_nm_lat: assert property (p_nm_lat) else $error("done late");
  property p_m_rd;
    tk && mem |=> O_DS_RD && O_IDX_UPD && O_DS_ADDR == $past(I_EADDR) ##2 O_DONE;
  endproperty
  a_m_rd: assert property (p_m_rd) else $error("store read wrong");
  property p_rd1; O_DS_RD |=> !O_DS_RD && !O_IDX_UPD; endproperty
  a_rd1: assert property (p_rd1) else $error("read too long");
  property p_wbd; O_WB_EN |-> O_DONE && O_WB_DATA == O_ACC; endproperty
  a_wbd: assert property (p_wbd) else $error("acc differs");
  property p_z; O_WB_EN |-> O_FLAG_Z == (O_ACC == 8'h00); endproperty
  a_z: assert property (p_z) else $error("zero flag");
  property p_lc;
    tk && !mem && lg |-> ##2 $stable(O_FLAG_C) && O_FLAG_C == $past(O_FLAG_C, 2);
  endproperty
  a_lc: assert property (p_lc) else $error("logic moved carry");
  property p_lm; tk && mem && lg |-> ##3 O_FLAG_V == $past(O_FLAG_V, 3); endproperty
  a_lm: assert property (p_lm) else $error("logic moved overflow");
  property p_dec;
    tk && I_OP_CODE == 4'h0 && I_OP_FORM == 3'h1 |-> ##2
      O_FLAG_C == ($past(I_REG1, 2) != 8'h00) && O_ACC == $past(I_REG1, 2) - 8'h01;
  endproperty
  a_dec: assert property (p_dec) else $error("dec wrong");
  property p_add;
    tk && I_OP_CODE == 4'h5 && I_OP_FORM == 3'h0 |-> ##2
      {O_FLAG_C, O_ACC} == {1'b0, $past(I_REG1, 2)} + $past(I_IMM, 2);
  endproperty
  a_add: assert property (p_add) else $error("add wrong");
  property p_subs;
    tk && I_OP_CODE == 4'h9 && I_OP_FORM == 3'h0 |-> ##2
      O_ACC == $past(I_REG1, 2) - $past(I_IMM, 2) &&
      O_FLAG_C == ($past(I_REG1, 2) >= $past(I_IMM, 2));
  endproperty
  a_subs: assert property (p_subs) else $error("subs wrong");
  c_mem: cover property (tk && mem);
  c_bad: cover property (O_DONE && !O_WB_EN);
  c_zero: cover property (O_WB_EN && O_FLAG_Z);
endmodule // alu_core_chk
bind alu_core alu_core_chk alu_core_chk_i (.*);
`default_nettype wire

// ==== dv/alu_dstore_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module alu_dstore_model (
  input wire logic        i_clk,
  input wire logic        i_rd,
  input wire logic [15:0] i_addr,
  output var logic [7:0]  o_rdata
);
  // answers one cycle after a read, toggles garbage otherwise
  initial o_rdata = 8'h00;
  always @(posedge i_clk) begin
    if (i_rd) o_rdata <= i_addr[15:8] ^ i_addr[7:0];
    else o_rdata <= ~o_rdata;
  end
endmodule // alu_dstore_model
`default_nettype wire

// ==== dv/alu_core_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module alu_core_tb;
  logic clk = 0, rst = 1, vld = 0, ec = 0, ev = 0;
  logic [3:0] code = 0, dsel = 0;
  logic [2:0] form = 0;
  logic [7:0] r1 = 0, r2 = 0, r3 = 0, imm = 0;
  logic [15:0] ea = 0;
  wire [7:0] rd, wbd, acc;
  wire [15:0] dsa;
  wire [3:0] wbs;
  wire busy, dsrd, idx, wbe, fc, fv, fz, done;
  integer errors = 0, n_tests = 0;
  alu_core alu_core_i (.I_REF_CLK(clk), .I_SYS_RST(rst), .I_OP_VALID(vld),
    .I_OP_CODE(code), .I_OP_FORM(form), .I_DST_SEL(dsel), .I_REG1(r1),
    .I_REG2(r2), .I_REG3(r3), .I_IMM(imm), .I_EADDR(ea), .I_DS_RDATA(rd),
    .O_BUSY(busy), .O_DS_RD(dsrd), .O_DS_ADDR(dsa), .O_IDX_UPD(idx),
    .O_WB_EN(wbe), .O_WB_SEL(wbs), .O_WB_DATA(wbd), .O_ACC(acc),
    .O_FLAG_C(fc), .O_FLAG_V(fv), .O_FLAG_Z(fz), .O_DONE(done));
  alu_dstore_model alu_dstore_model_i (.i_clk(clk), .i_rd(dsrd), .i_addr(dsa),
    .o_rdata(rd));
  initial forever #4 clk = ~clk;
  task chk(input [7:0] s, e, input string m);
    begin
      n_tests++;
      if (s !== e) begin
        errors++;
        $display("[FAIL] %0t %s", $time, m);
      end
    end
  endtask
  function automatic [9:0] ref_f(input [3:0] op, input [2:0] f, input [7:0] x, y,
    input c, v);
    logic [7:0] a, b;
    logic [8:0] s;
    logic k, w;
    begin
      a = x; b = y; k = c; w = v; s = 9'h000;
      if (op >= 4'h7 && ((op <= 4'h8) ^ (f == 3'h3))) begin a = y; b = x; end
      case (op)
        4'h0, 4'h1: begin
          a = (f == 3'h4 || f == 3'h2) ? y : x;
          s = a - (op == 4'h0 ? 9'h001 : {8'h00, !c});
          k = !(s[7:0] == 8'hFF && (op == 4'h0 || !c));
          w = a[7] & ~s[7];
        end
        4'h2: s = a & b;
        4'h3: s = a | b;
        4'h4: s = a ^ b;
        4'h5, 4'h6: begin
          s = a + b + (op == 4'h6 ? c : 1'b0);
          k = s[8];
          w = (a[7] == b[7]) && (s[7] != a[7]);
        end
        4'h7, 4'h8, 4'h9, 4'hA: begin
          s = a - b - ((op == 4'h8 || op == 4'hA) ? !c : 1'b0);
          k = ~s[8];
          w = (a[7] != b[7]) && (s[7] != a[7]);
        end
        default: s = 9'h000;
      endcase
      ref_f = {k, w, s[7:0]};
    end
  endfunction
  task run(input [3:0] op, input [2:0] f, input [7:0] a1, a2, a3, im);
    logic [9:0] e;
    logic [7:0] x, y, n;
    begin
      x = (f == 3'h3) ? a2 : a1;
      y = (f == 3'h0) ? im : (f == 3'h2) ? a2 : (f == 3'h3) ? a3 : (a2 ^ a3);
      e = ref_f(op, f, x, y, ec, ev);
      @(posedge clk);
      vld <= 1'b1; code <= op; form <= f; dsel <= ~op;
      r1 <= a1; r2 <= a2; r3 <= a3; imm <= im; ea <= {a3, a2};
      @(posedge clk);
      vld <= 1'b0;
      #1;
      chk(busy, 1'b1, "busy");
      n = 0;
      do begin @(posedge clk); #1; n++; end while (done !== 1'b1 && n < 9);
      chk(n, (f == 3'h4) ? 8'h02 : 8'h01, "latency");
      chk(busy, 1'b0, "idle");
      chk(wbe, op <= 4'hA, "write enable");
      if (op <= 4'hA) begin
        chk(acc, e[7:0], "acc");
        chk(wbd, e[7:0], "result");
        chk({4'h0, wbs}, {4'h0, ~op}, "dest");
        chk(fz, e[7:0] == 8'h00, "zero");
        chk(fv, e[8], "overflow");
        ec = e[9];
        ev = e[8];
      end
      chk(fc, ec, "carry");
    end
  endtask
  task t_dec;
    begin
      run(4'h0, 3'h1, 8'h00, 8'h00, 8'h00, 8'h00);
      run(4'h1, 3'h1, 8'h00, 8'h00, 8'h00, 8'h00);
      run(4'h1, 3'h1, 8'hFF, 8'h00, 8'h00, 8'h00);
      run(4'h1, 3'h1, 8'hFF, 8'h00, 8'h00, 8'h00);
      run(4'h0, 3'h1, 8'h80, 8'h00, 8'h00, 8'h00);
      run(4'h0, 3'h4, 8'h00, 8'h34, 8'h12, 8'h00);
      run(4'h1, 3'h4, 8'h00, 8'h01, 8'h01, 8'h00);
      run(4'h0, 3'h2, 8'h55, 8'h00, 8'h00, 8'h00);
      run(4'h1, 3'h2, 8'h55, 8'h80, 8'h00, 8'h00);
      $display("t_dec end");
    end
  endtask
  task t_logic;
    integer i, j;
    begin
      run(4'h5, 3'h0, 8'hFF, 8'h00, 8'h00, 8'h80);
      for (i = 2; i <= 4; i++)
        for (j = 0; j <= 4; j++)
          if (j != 1) run(i[3:0], j[2:0], 8'hC3, 8'h5A, 8'h0F, 8'h3C);
      run(4'h2, 3'h0, 8'h0F, 8'h00, 8'h00, 8'hF0);
      $display("t_logic end");
    end
  endtask
  task t_arith(input [3:0] lo, hi, input [7:0] a1, a2, a3, im);
    integer i, j;
    begin
      for (i = lo; i <= hi; i++)
        for (j = 0; j <= 4; j++)
          if (j != 1) run(i[3:0], j[2:0], a1, a2, a3, im);
      $display("t_arith end");
    end
  endtask
  task t_bad;
    begin
      run(4'hB, 3'h0, 8'h12, 8'h00, 8'h00, 8'h34);
      run(4'hF, 3'h4, 8'h12, 8'h00, 8'h00, 8'h34);
      $display("t_bad end");
    end
  endtask
  task print_verdict;
    begin
      $display("tests %0d errors %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) begin
        $display("SIMULATION PASSED");
      end else begin
        $display("SIMULATION FAILED");
      end
      $finish;
    end
  endtask
  initial begin
    #20000;
    errors++;
    print_verdict;
  end
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_dec;
    t_logic;
    t_arith(4'h5, 4'h6, 8'hFF, 8'h01, 8'h7F, 8'h01);
    t_arith(4'h7, 4'hA, 8'h10, 8'h20, 8'h90, 8'h10);
    t_arith(4'h7, 4'hA, 8'h80, 8'h7F, 8'h00, 8'hFF);
    t_bad;
    print_verdict;
  end
endmodule // alu_core_tb
`default_nettype wire
